// *** src/sli_status_led_top.sv ***
// Functional notes
// [RL1] Five lamps are driven: supply, one link lamp per network port, and two red/green lamps.
// [RL2] Blinking toggles the lamp with 200 ms on and 200 ms off, 2.5 Hz.
// [RL3] Flickering flashes the lamp with a period of about 50 ms, about 20 Hz.
// [RL4] A link lamp is dark without link, steady with link, and flickers on traffic.
// [RL5] Module lamp: off unpowered, green ok, blink green unconfigured, red major, blink red minor.
// [RL6] Network lamp: off no address, green open, blink green none, red duplicate, blink red timeout.
// [RL7] During self-test both red/green lamps alternate red and green. The module lamp here stays off while module_powered is low.
// [RL8] Supply lamp: off no supply, green supply, flicker if motor silent, red undervoltage.
// [RL9] The most severe active condition of a lamp wins: self-test, major, minor, then normal.
// [RL10] Blink and flicker timing come from reset-cleared free-running counters, so lamps share phase.
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module sli_status_led_top
    import sli_pkg::*;
#(
    parameter logic [SLI_CNT_W-1:0] BLINK_HALF_CYCLES   = SLI_BLINK_HALF_CYCLES,
    parameter logic [SLI_CNT_W-1:0] FLICKER_HALF_CYCLES = SLI_FLICKER_HALF_CYCLES
)
(
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // AXI4-Lite slave
    input  wire logic [SLI_ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic [2:0]               s_axi_awprot,
    input  wire logic                     s_axi_awvalid,
    output wire logic                     s_axi_awready,
    input  wire logic [SLI_DATA_W-1:0]    s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output wire logic                     s_axi_wready,
    output wire logic [1:0]               s_axi_bresp,
    output wire logic                     s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [SLI_ADDR_W-1:0]    s_axi_araddr,
    input  wire logic [2:0]               s_axi_arprot,
    input  wire logic                     s_axi_arvalid,
    output wire logic                     s_axi_arready,
    output wire logic [SLI_DATA_W-1:0]    s_axi_rdata,
    output wire logic [1:0]               s_axi_rresp,
    output wire logic                     s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // Conditions from module logic
    input  wire logic [SLI_NUM_PORTS-1:0] port_link_up,
    input  wire logic [SLI_NUM_PORTS-1:0] port_activity,
    input  wire logic                     module_powered,
    input  wire logic                     module_configured,
    input  wire logic                     self_test_active,
    input  wire logic                     major_fault,
    input  wire logic                     minor_fault,
    input  wire logic                     ip_assigned,
    input  wire logic                     cip_connection_open,
    input  wire logic                     duplicate_ip,
    input  wire logic                     connection_timeout,
    input  wire logic                     supply_present,
    input  wire logic                     motor_link_active,
    input  wire logic                     supply_undervoltage,
    // Lamp pins
    output wire logic                     first_port_link_lamp_alt,
    output wire logic                     second_port_link_lamp_alt,
    output wire logic                     module_state_lamp_green,
    output wire logic                     module_state_lamp_red,
    output wire logic                     network_state_lamp_green,
    output wire logic                     network_state_lamp_red,
    output wire logic                     supply_lamp_green,
    output wire logic                     supply_lamp_red
);

    sli_timebase_if tb_if ();

    sli_timebase #(
        .BLINK_HALF_CYCLES   (BLINK_HALF_CYCLES),
        .FLICKER_HALF_CYCLES (FLICKER_HALF_CYCLES)
    ) u_timebase (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tb      (tb_if.source)
    );

    // Pattern of one red/green lamp for the current phases, {red, green}
    function automatic logic [1:0] lamp_drive(input sli_lamp_mode_type mode,
                                             input logic blink,
                                             input logic flicker);
        logic [1:0] rg;
        rg = 2'h0;
        case (mode)
            SLI_LAMP_OFF:           rg = 2'h0;
            SLI_LAMP_STEADY_GREEN:  rg = 2'h1;
            SLI_LAMP_BLINK_GREEN:   rg = {1'b0, blink};
            SLI_LAMP_STEADY_RED:    rg = 2'h2;
            SLI_LAMP_BLINK_RED:     rg = {blink, 1'b0};
            SLI_LAMP_ALTERNATE:     rg = {~blink, blink};
            SLI_LAMP_FLICKER_GREEN: rg = {1'b0, flicker};
            default:                rg = 2'h0;
        endcase
        return rg;
    endfunction : lamp_drive

    // Register file
    logic [SLI_CTRL_W-1:0]   ctrl_reg;
    logic [SLI_ADDR_W-1:0]   aw_addr_reg;
    logic                    aw_held_reg;
    logic [SLI_DATA_W-1:0]   w_data_reg;
    logic [3:0]              w_strb_reg;
    logic                    w_held_reg;
    logic                    bvalid_reg;
    logic [1:0]              bresp_reg;
    logic                    rvalid_reg;
    logic [1:0]              rresp_reg;
    logic [SLI_DATA_W-1:0]   rdata_reg;

    wire                     aw_take;
    wire                     w_take;
    wire                     wr_do;
    wire                     wr_hit_ctrl;
    wire                     wr_hit_ro;
    wire                     ar_take;
    wire                     rd_hit_ctrl;
    wire                     rd_hit_status;
    wire                     rd_hit_cond;
    wire [SLI_DATA_W-1:0]    rd_value;
    wire [SLI_STATUS_W-1:0]  status_word;
    wire [SLI_COND_W-1:0]    cond_word;

    wire ctrl_enable    = ctrl_reg[SLI_CTRL_ENABLE];
    wire ctrl_uv_mon    = ctrl_reg[SLI_CTRL_UV_MON];
    wire ctrl_lamp_test = ctrl_reg[SLI_CTRL_LAMP_TEST];

    assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
    assign aw_take       = s_axi_awvalid & s_axi_awready;
    assign w_take        = s_axi_wvalid & s_axi_wready;
    assign wr_do         = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign wr_hit_ctrl   = (aw_addr_reg == SLI_CTRL_OFFSET);
    assign wr_hit_ro     = (aw_addr_reg == SLI_STATUS_OFFSET) | (aw_addr_reg == SLI_COND_OFFSET);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_held_reg  <= 1'b0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            else if (wr_do)
                aw_held_reg <= 1'b0;
            if (w_take)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            else if (wr_do)
                w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_reg   <= SLI_CTRL_RESET;
            bvalid_reg <= 1'b0;
            bresp_reg  <= SLI_RESP_OKAY;
        end
        else
        begin
            if (wr_do)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= (wr_hit_ctrl | wr_hit_ro) ? SLI_RESP_OKAY : SLI_RESP_SLVERR;
                if (wr_hit_ctrl & w_strb_reg[0])
                    ctrl_reg <= w_data_reg[SLI_CTRL_W-1:0];
            end
            else if (bvalid_reg & s_axi_bready)
                bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    assign s_axi_arready = ~rvalid_reg;
    assign ar_take       = s_axi_arvalid & s_axi_arready;
    assign rd_hit_ctrl   = (s_axi_araddr == SLI_CTRL_OFFSET);
    assign rd_hit_status = (s_axi_araddr == SLI_STATUS_OFFSET);
    assign rd_hit_cond   = (s_axi_araddr == SLI_COND_OFFSET);
    assign rd_value      = rd_hit_ctrl   ? SLI_DATA_W'(ctrl_reg)    :
                           rd_hit_status ? SLI_DATA_W'(status_word) :
                           rd_hit_cond   ? SLI_DATA_W'(cond_word)   : '0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= SLI_RESP_OKAY;
            rdata_reg  <= '0;
        end
        else if (ar_take)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_value;
            rresp_reg  <= (rd_hit_ctrl | rd_hit_status | rd_hit_cond) ?
                          SLI_RESP_OKAY : SLI_RESP_SLVERR;
        end
        else if (rvalid_reg & s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;

    // Lamp state selection
    sli_lamp_mode_type module_mode;
    sli_lamp_mode_type network_mode;
    sli_lamp_mode_type supply_mode;

    wire blink   = tb_if.blink_phase;
    wire flicker = tb_if.flicker_phase;

    // [RL5] Module lamp states
    // [RL7] Self-test alternates colours
    // [RL9] Severity order
    assign module_mode = !module_powered    ? SLI_LAMP_OFF          :
                         self_test_active   ? SLI_LAMP_ALTERNATE    :
                         major_fault        ? SLI_LAMP_STEADY_RED   :
                         minor_fault        ? SLI_LAMP_BLINK_RED    :
                         !module_configured ? SLI_LAMP_BLINK_GREEN  :
                                              SLI_LAMP_STEADY_GREEN;

    // [RL6] Network lamp states
    // [RL7] Self-test alternates colours
    // [RL9] Severity order
    assign network_mode = self_test_active    ? SLI_LAMP_ALTERNATE    :
                          duplicate_ip        ? SLI_LAMP_STEADY_RED   :
                          connection_timeout  ? SLI_LAMP_BLINK_RED    :
                          !ip_assigned        ? SLI_LAMP_OFF          :
                          cip_connection_open ? SLI_LAMP_STEADY_GREEN :
                                                SLI_LAMP_BLINK_GREEN;

    // [RL8] Supply lamp states
    assign supply_mode = !supply_present                    ? SLI_LAMP_OFF           :
                         (supply_undervoltage & ctrl_uv_mon) ? SLI_LAMP_STEADY_RED    :
                         !motor_link_active                 ? SLI_LAMP_FLICKER_GREEN :
                                                              SLI_LAMP_STEADY_GREEN;

    wire [1:0] module_rg  = lamp_drive(module_mode, blink, flicker);
    wire [1:0] network_rg = lamp_drive(network_mode, blink, flicker);
    wire [1:0] supply_rg  = lamp_drive(supply_mode, blink, flicker);

    logic [SLI_NUM_PORTS-1:0] act_seen_reg;
    logic [SLI_NUM_PORTS-1:0] link_lamp_reg;
    wire  [SLI_NUM_PORTS-1:0] link_lamp_next;

    genvar gi;
    generate
        for (gi = 0; gi < SLI_NUM_PORTS; gi++)
        begin : g_port
            // Short traffic pulses are held until the next flicker wrap, at most one flicker period; a new pulse wins
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    act_seen_reg[gi] <= 1'b0;
                else
                    act_seen_reg[gi] <= port_activity[gi] |
                                        (act_seen_reg[gi] & ~tb_if.flicker_wrap);
            end
            // [RL4] Link and traffic
            assign link_lamp_next[gi] = !port_link_up[gi] ? 1'b0    :
                                        act_seen_reg[gi]  ? flicker : 1'b1;
        end
    endgenerate

    logic [1:0] module_rg_reg;
    logic [1:0] network_rg_reg;
    logic [1:0] supply_rg_reg;

    // [RL1] Five lamps driven from flops
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            link_lamp_reg  <= '0;
            module_rg_reg  <= 2'h0;
            network_rg_reg <= 2'h0;
            supply_rg_reg  <= 2'h0;
        end
        else if (ctrl_lamp_test)
        begin
            link_lamp_reg  <= '1;
            module_rg_reg  <= 2'h1;
            network_rg_reg <= 2'h1;
            supply_rg_reg  <= 2'h1;
        end
        else if (ctrl_enable)
        begin
            link_lamp_reg  <= link_lamp_next;
            module_rg_reg  <= module_rg;
            network_rg_reg <= network_rg;
            supply_rg_reg  <= supply_rg;
        end
        else
        begin
            link_lamp_reg  <= '0;
            module_rg_reg  <= 2'h0;
            network_rg_reg <= 2'h0;
            supply_rg_reg  <= 2'h0;
        end
    end

    assign first_port_link_lamp_alt  = link_lamp_reg[0];
    assign second_port_link_lamp_alt = link_lamp_reg[1];
    assign module_state_lamp_green   = module_rg_reg[0];
    assign module_state_lamp_red     = module_rg_reg[1];
    assign network_state_lamp_green  = network_rg_reg[0];
    assign network_state_lamp_red    = network_rg_reg[1];
    assign supply_lamp_green         = supply_rg_reg[0];
    assign supply_lamp_red           = supply_rg_reg[1];

    assign status_word = {flicker, blink, supply_rg_reg, network_rg_reg,
                          module_rg_reg, link_lamp_reg};

    assign cond_word = {2'h0, supply_undervoltage, motor_link_active, supply_present,
                        connection_timeout, duplicate_ip, cip_connection_open, ip_assigned,
                        minor_fault, major_fault, self_test_active, module_configured,
                        module_powered, act_seen_reg};

endmodule : sli_status_led_top

// *** src/sli_pkg.sv ***
package sli_pkg;

    // Clock rate and documented lamp timing
    localparam int unsigned SLI_CLK_KHZ           = 250000;
    localparam int unsigned SLI_BLINK_HALF_MS     = 200;
    localparam int unsigned SLI_FLICKER_PERIOD_MS = 50;

    localparam int unsigned SLI_CNT_W = 26;

    localparam int unsigned SLI_BLINK_HALF_CYC_INT   = SLI_BLINK_HALF_MS * SLI_CLK_KHZ;
    localparam int unsigned SLI_FLICKER_HALF_CYC_INT = (SLI_FLICKER_PERIOD_MS * SLI_CLK_KHZ) / 2;

    localparam logic [SLI_CNT_W-1:0] SLI_BLINK_HALF_CYCLES   = SLI_CNT_W'(SLI_BLINK_HALF_CYC_INT);
    localparam logic [SLI_CNT_W-1:0] SLI_FLICKER_HALF_CYCLES =
        SLI_CNT_W'(SLI_FLICKER_HALF_CYC_INT);

    localparam int unsigned SLI_NUM_PORTS = 2;

    // Register bus
    localparam int unsigned SLI_ADDR_W = 4;
    localparam int unsigned SLI_DATA_W = 32;

    localparam logic [SLI_ADDR_W-1:0] SLI_CTRL_OFFSET   = 4'h0;
    localparam logic [SLI_ADDR_W-1:0] SLI_STATUS_OFFSET = 4'h4;
    localparam logic [SLI_ADDR_W-1:0] SLI_COND_OFFSET   = 4'h8;

    localparam logic [1:0] SLI_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SLI_RESP_SLVERR = 2'h2;

    // Control register fields
    localparam int unsigned SLI_CTRL_W         = 3;
    localparam int unsigned SLI_CTRL_ENABLE    = 0;
    localparam int unsigned SLI_CTRL_UV_MON    = 1;
    localparam int unsigned SLI_CTRL_LAMP_TEST = 2;
    localparam logic [SLI_CTRL_W-1:0] SLI_CTRL_RESET = 3'h3;

    // Status register layout: lamp outputs then timebase phases
    localparam int unsigned SLI_STATUS_W = 10;
    // Condition register layout
    localparam int unsigned SLI_COND_W = 16;

    typedef enum logic [2:0] {
        SLI_LAMP_OFF,
        SLI_LAMP_STEADY_GREEN,
        SLI_LAMP_BLINK_GREEN,
        SLI_LAMP_STEADY_RED,
        SLI_LAMP_BLINK_RED,
        SLI_LAMP_ALTERNATE,
        SLI_LAMP_FLICKER_GREEN
    } sli_lamp_mode_type;

endpackage : sli_pkg

// *** src/sli_timebase_if.sv ***
`timescale 1ns/100ps
interface sli_timebase_if;
    logic blink_phase;
    logic flicker_phase;
    logic flicker_wrap;

    modport source (output blink_phase, output flicker_phase, output flicker_wrap);
    modport sink   (input  blink_phase, input  flicker_phase, input  flicker_wrap);
endinterface : sli_timebase_if

// *** src/sli_timebase.sv ***
`timescale 1ns/100ps
module sli_timebase
    import sli_pkg::*;
#(
    parameter logic [SLI_CNT_W-1:0] BLINK_HALF_CYCLES   = SLI_BLINK_HALF_CYCLES,
    parameter logic [SLI_CNT_W-1:0] FLICKER_HALF_CYCLES = SLI_FLICKER_HALF_CYCLES
)
(
    input  wire logic          aclk,
    input  wire logic          aresetn,
    sli_timebase_if.source     tb
);

    logic [SLI_CNT_W-1:0] blink_cnt_reg;
    logic [SLI_CNT_W-1:0] blink_cnt_next;
    logic [SLI_CNT_W-1:0] flick_cnt_reg;
    logic [SLI_CNT_W-1:0] flick_cnt_next;
    logic                 blink_phase_reg;
    logic                 flick_phase_reg;
    logic                 flick_wrap_reg;
    wire                  blink_end;
    wire                  flick_end;

    assign blink_end      = (blink_cnt_reg == (BLINK_HALF_CYCLES - 26'h0000001));
    assign flick_end      = (flick_cnt_reg == (FLICKER_HALF_CYCLES - 26'h0000001));
    assign blink_cnt_next = blink_end ? '0 : blink_cnt_reg + 26'h0000001;
    assign flick_cnt_next = flick_end ? '0 : flick_cnt_reg + 26'h0000001;

    // [RL10] Free running phases
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            blink_cnt_reg   <= '0;
            flick_cnt_reg   <= '0;
            blink_phase_reg <= 1'b0;
            flick_phase_reg <= 1'b0;
            flick_wrap_reg  <= 1'b0;
        end
        else
        begin
            blink_cnt_reg <= blink_cnt_next;
            flick_cnt_reg <= flick_cnt_next;
            // [RL2] Equal half periods
            if (blink_end)
                blink_phase_reg <= ~blink_phase_reg;
            // [RL3] Fast flicker period
            if (flick_end)
                flick_phase_reg <= ~flick_phase_reg;
            flick_wrap_reg <= flick_end & flick_phase_reg;
        end
    end

    assign tb.blink_phase   = blink_phase_reg;
    assign tb.flicker_phase = flick_phase_reg;
    assign tb.flicker_wrap  = flick_wrap_reg;

endmodule : sli_timebase

// *** test/sli_lamp_viewer.sv ***
`timescale 1ns/100ps
module sli_lamp_viewer
(
    input  wire logic aclk,
    input  wire logic lamp,
    output int        run
);
    int   cnt  = 0;
    logic last = 1'b0;

    // Operator sees the time between lamp changes
    always @(posedge aclk)
    begin
        cnt <= (lamp != last) ? 1 : cnt + 1;
        if (lamp != last)
            run <= cnt;
        last <= lamp;
    end
endmodule : sli_lamp_viewer

// *** test/sli_status_led_properties.sv ***
`timescale 1ns/100ps
module sli_status_led_properties
    import sli_pkg::*;
(
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic [SLI_DATA_W-1:0] s_axi_rdata,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    input wire logic                  module_powered,
    input wire logic                  self_test_active,
    input wire logic                  major_fault,
    input wire logic                  minor_fault,
    input wire logic                  duplicate_ip,
    input wire logic                  connection_timeout,
    input wire logic                  supply_present,
    input wire logic                  supply_undervoltage,
    input wire logic                  module_state_lamp_green,
    input wire logic                  module_state_lamp_red,
    input wire logic                  network_state_lamp_green,
    input wire logic                  network_state_lamp_red,
    input wire logic                  supply_lamp_red
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_answer;
        ##2 s_axi_bvalid;
    endsequence

    wr_resp_a: assert property (wr_taken |-> wr_answer)
        else $error("write response not on time");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not on time");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    mod_red_cause_a: assert property (!(module_powered &&
        (self_test_active || major_fault || minor_fault)) |=> !module_state_lamp_red)
        else $error("module red unexpected");
    colour_excl_a: assert property (!(module_state_lamp_green && module_state_lamp_red) &&
        !(network_state_lamp_green && network_state_lamp_red)) else $error("both colours lit");
    net_red_cause_a: assert property (!(self_test_active || duplicate_ip ||
        connection_timeout) |=> !network_state_lamp_red) else $error("network red unexpected");
    supply_red_a: assert property (!(supply_present && supply_undervoltage) |=>
        !supply_lamp_red) else $error("supply red unexpected");
endmodule : sli_status_led_properties

bind sli_status_led_top sli_status_led_properties chk_u (.*);

// *** test/test_status_led_indicator_driver.sv ***
`timescale 1ns/100ps
module test_status_led_indicator_driver
    import sli_pkg::*;
;
    localparam int BLINK = 20;
    localparam int FLICK = 5;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [SLI_ADDR_W-1:0]    s_axi_awaddr, s_axi_araddr;
    logic [2:0]               s_axi_awprot, s_axi_arprot;
    logic [SLI_DATA_W-1:0]    s_axi_wdata;
    logic [3:0]               s_axi_wstrb;
    logic [SLI_NUM_PORTS-1:0] port_link_up, port_activity;
    logic module_powered, module_configured, self_test_active, major_fault, minor_fault;
    logic ip_assigned, cip_connection_open, duplicate_ip, connection_timeout;
    logic supply_present, motor_link_active, supply_undervoltage;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0]            s_axi_bresp, s_axi_rresp;
    wire logic [SLI_DATA_W-1:0] s_axi_rdata;
    wire logic first_port_link_lamp_alt, second_port_link_lamp_alt, module_state_lamp_green;
    wire logic module_state_lamp_red, network_state_lamp_green, network_state_lamp_red;
    wire logic supply_lamp_green, supply_lamp_red;
    wire logic [7:0] lamps = {supply_lamp_red, supply_lamp_green, network_state_lamp_red,
        network_state_lamp_green, module_state_lamp_red, module_state_lamp_green,
        second_port_link_lamp_alt, first_port_link_lamp_alt};
    int run [8];
    int error_cnt = 0;
    int n_compared = 0;

    sli_status_led_top #(
        .BLINK_HALF_CYCLES  (SLI_CNT_W'(BLINK)),
        .FLICKER_HALF_CYCLES(SLI_CNT_W'(FLICK))
    ) dut_u (.*);

    for (genvar i = 0; i < 8; i++)
    begin : g_view
        sli_lamp_viewer view_u (.aclk(aclk), .lamp(lamps[i]), .run(run[i]));
    end

    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic test_done;
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic limit(input int n);
        check(n >= 40, 1'b0);
        if (n >= 40)
            test_done();
    endtask : limit

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int   n;
        logic aw, w, bv, b;
        logic [1:0] rs;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w  = s_axi_wvalid && s_axi_wready;
            bv = s_axi_bvalid;
            b  = bv && s_axi_bready;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (aw)
                s_axi_awvalid <= 1'b0;
            if (w)
                s_axi_wvalid <= 1'b0;
            if (b)
                break;
            s_axi_bready <= bv;
        end
        s_axi_bready <= 1'b0;
        limit(n);
        check(rs, r);
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] d,
                          input logic [1:0] r);
        int   n;
        logic ar, rv, rh;
        logic [31:0] rd;
        logic [1:0]  rs;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            rv = s_axi_rvalid;
            rh = rv && s_axi_rready;
            rd = s_axi_rdata & m;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ar)
                s_axi_arvalid <= 1'b0;
            if (rh)
                break;
            s_axi_rready <= rv;
        end
        s_axi_rready <= 1'b0;
        limit(n);
        check(rd, d);
        check(rs, r);
    endtask : axi_rd

    task automatic set_cond(input logic [15:0] c);
        {supply_undervoltage, motor_link_active, supply_present, connection_timeout, duplicate_ip,
         cip_connection_open, ip_assigned, minor_fault, major_fault, self_test_active,
         module_configured, module_powered, port_activity, port_link_up} <= c;
    endtask : set_cond

    // Steady lamps, mirrored in the status and condition registers
    task automatic steady(input logic [15:0] c, input logic [7:0] e);
        set_cond(c);
        repeat (12) @(posedge aclk);
        check(lamps, e);
        axi_rd(SLI_STATUS_OFFSET, 32'hFFFFFCFF, {24'h0, e}, SLI_RESP_OKAY);
        axi_rd(SLI_COND_OFFSET, 32'hFFFFFFFC, {18'h0, c[15:4], 2'h0}, SLI_RESP_OKAY);
    endtask : steady

    // Two lamps flashing with the given half period
    task automatic flash(input logic [15:0] c, input int i, input int j, input int p);
        set_cond(c);
        repeat (70) @(posedge aclk);
        check(run[i], p);
        check(run[j], p);
    endtask : flash

    task automatic ctrl_test;
        axi_rd(SLI_CTRL_OFFSET, 32'hFFFFFFFF, 32'h3, SLI_RESP_OKAY);
        axi_rd(4'hC, 32'hFFFFFFFF, 32'h0, SLI_RESP_SLVERR);
        axi_wr(4'hC, 32'h0, SLI_RESP_SLVERR);
        axi_wr(SLI_STATUS_OFFSET, 32'hFF, SLI_RESP_OKAY);
        axi_wr(SLI_CTRL_OFFSET, 32'h1, SLI_RESP_OKAY);
        steady(16'hE682, 8'h52);
        axi_wr(SLI_CTRL_OFFSET, 32'h5, SLI_RESP_OKAY);
        steady(16'hE682, 8'h57);
        axi_wr(SLI_CTRL_OFFSET, 32'h0, SLI_RESP_OKAY);
        steady(16'hE682, 8'h00);
        axi_wr(SLI_CTRL_OFFSET, 32'h3, SLI_RESP_OKAY);
        s_axi_wstrb <= 4'hE;
        axi_wr(SLI_CTRL_OFFSET, 32'h0, SLI_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        axi_rd(SLI_CTRL_OFFSET, 32'hFFFFFFFF, 32'h3, SLI_RESP_OKAY);
    endtask : ctrl_test

    initial
    begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        set_cond(16'h0);
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        steady(16'h0000, 8'h00);
        steady(16'h6633, 8'h57);
        steady(16'hFFB1, 8'hA9);
        steady(16'hE682, 8'h92);
        ctrl_test();
        flash(16'h6210, 2, 4, BLINK);
        check(module_state_lamp_green, network_state_lamp_green);
        flash(16'h7730, 3, 5, BLINK);
        flash(16'h6050, 2, 5, BLINK);
        flash(16'h2005, 0, 6, FLICK);
        test_done();
    end
endmodule : test_status_led_indicator_driver
